// File: pme_consts.svh
// Constants for the power meter entry and error status block.
// Assumes inclusion by bare name from the block and the bench.
`ifndef PME_CONSTS_SVH
`define PME_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PME_CTRL_OFS 8'h00
`define PME_CMD_OFS 8'h04
`define PME_REMOTE_CF_OFS 8'h08
`define PME_MEAS_A_OFS 8'h0C
`define PME_MEAS_B_OFS 8'h10
`define PME_EXT_ERR_OFS 8'h14
`define PME_REFCAL_OFS 8'h18
`define PME_CF_A_OFS 8'h1C
`define PME_CF_B_OFS 8'h20
`define PME_RESULT_OFS 8'h24
`define PME_STATUS_OFS 8'h28
`define PME_STATMSG_OFS 8'h2C
// ----------------------------------------
// Field positions and control reset value
// ----------------------------------------
`define PME_CTRL_CHAN 0
`define PME_CTRL_REL 1
`define PME_CTRL_MODE_LO 2
`define PME_CTRL_MODE_HI 3
`define PME_CTRL_CAL 4
`define PME_CTRL_SRQ_MEAS 5
`define PME_CTRL_SRQ_ENT 6
`define PME_CTRL_RST 7'h00
`define PME_CMD_DIG_LO 4
`define PME_CMD_DIG_HI 7
// ----------------------------------------
// Factor values in tenths of a percent, digit limit and scaling figures
// ----------------------------------------
`define PME_CF_MIN 32'h0000000A
`define PME_CF_MAX 32'h000005DC
`define PME_CF_UNITY 16'h03E8
`define PME_MAX_DIGITS 3'h4
`define PME_TEN 32'h0000000A
`define PME_HALF 32'h00000005
`define PME_PCT_SCALE 49'sh0003E8
// ----------------------------------------
// Error codes and class bounds
// ----------------------------------------
`define PME_ERR_NONE 8'h00
`define PME_ERR_LOG 8'h1B
`define PME_ERR_CF_RANGE 8'h32
`define PME_MEAS_LO 8'h01
`define PME_MEAS_HI 8'h31
`define PME_ENT_LO 8'h32
`define PME_ENT_HI 8'h3B
`define PME_SVC_LO 8'h3C
`define PME_SVC_HI 8'h45
`define PME_ENT2_LO 8'h5A
`define PME_ENT2_HI 8'h63
// Marker word standing for 9.0000E+40 (arbitrary encoding)
`define PME_SENTINEL 32'h7FC09E40
`endif

// File: pme_pkg.sv
// Types shared by the power meter entry and error status block.
// Assumes no other package.
package pme_pkg;
  // Keypad entry state
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_entry = 1'b1
  } pme_state_type;
  // Command codes written to the command register
  typedef enum logic [3:0] {
    op_none = 4'h0,
    op_sensor_gain_factor_cmd = 4'h1,
    op_digit = 4'h2,
    op_point = 4'h3,
    op_enter = 4'h4,
    op_log_units_cmd = 4'h5,
    op_linear_units_cmd = 4'h6,
    op_unit_toggle_key = 4'h7,
    op_preset = 4'h8
  } pme_op_type;
  // Error groups
  typedef enum logic [1:0] {
    cls_none = 2'h0,
    cls_meas = 2'h1,
    cls_entry = 2'h2,
    cls_service = 2'h3
  } pme_class_type;
endpackage : pme_pkg

// File: pme_entry_status.sv
// Calibration factor entry, unit selection and error status of a
// two channel power meter, reached as an APB slave.
// Assumes one 50 MHz clock and measurement words written by software.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ns
`include "pme_consts.svh"
`default_nettype none

module pme_entry_status (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Panel and bus status
  output logic entry_prompt,
  output logic unit_is_log,
  output logic error_shown,
  output logic srq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Factor range check
  function automatic logic cf_ok(input logic [31:0] v);
    cf_ok = (v >= `PME_CF_MIN) && (v <= `PME_CF_MAX);
  endfunction : cf_ok

  // Error group of a code
  function automatic pme_pkg::pme_class_type err_class(input logic [7:0] c);
    if (c >= `PME_MEAS_LO && c <= `PME_MEAS_HI) begin
      err_class = pme_pkg::cls_meas;
    end else if ((c >= `PME_ENT_LO && c <= `PME_ENT_HI) ||
                 (c >= `PME_ENT2_LO && c <= `PME_ENT2_HI)) begin
      err_class = pme_pkg::cls_entry;
    end else if (c >= `PME_SVC_LO && c <= `PME_SVC_HI) begin
      err_class = pme_pkg::cls_service;
    end else begin
      err_class = pme_pkg::cls_none;
    end
  endfunction : err_class

  // Reading times factor in tenths of a percent
  function automatic logic signed [31:0] scale(input logic signed [31:0] m,
                                               input logic [15:0] g);
    logic signed [48:0] p;
    p = 49'(m) * $signed({1'b0, g});
    scale = 32'(p / `PME_PCT_SCALE);
  endfunction : scale

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0] ctrl; // Channel, relative, mode, calibration, masks
  pme_pkg::pme_state_type state; // Keypad entry state
  logic [15:0] cf_a; // Channel A factor
  logic [15:0] cf_b; // Channel B factor
  logic [15:0] refcal; // Reference factor
  logic [15:0] acc; // Integer digits keyed
  logic [3:0] frac; // Fractional digit keyed
  logic [2:0] dcnt; // Digits kept
  logic point_seen; // Decimal point keyed
  logic frac_seen; // Fractional digit kept
  logic signed [31:0] meas_a; // Raw reading A
  logic signed [31:0] meas_b; // Raw reading B
  logic signed [31:0] ref_val; // Relative reference
  logic meas_upd; // Reading written last cycle
  logic rel_arm; // Waiting for first relative reading
  logic [7:0] ext_err; // Error from other logic
  logic [7:0] entry_err; // Entry error pending
  logic [7:0] err_prev; // Error code last cycle
  logic [7:0] stat_code; // Latched status message code
  logic meas_pend; // Measurement error awaits sentinel

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic setup = psel & ~penable;
  wire logic acc_ph = psel & penable & pready;
  wire logic wr_en = acc_ph & pwrite;
  wire logic rd_en = acc_ph & ~pwrite;
  wire logic cmd_wr = wr_en && (paddr == `PME_CMD_OFS);
  wire logic ctrl_wr = wr_en && (paddr == `PME_CTRL_OFS);
  wire logic remote_wr = wr_en && (paddr == `PME_REMOTE_CF_OFS);
  wire logic ma_wr = wr_en && (paddr == `PME_MEAS_A_OFS);
  wire logic mb_wr = wr_en && (paddr == `PME_MEAS_B_OFS);
  wire logic [3:0] op = pwdata[3:0];
  wire logic [3:0] digit = pwdata[`PME_CMD_DIG_HI:`PME_CMD_DIG_LO];
  wire logic preset = cmd_wr && (op == pme_pkg::op_preset);
  wire logic chan = ctrl[`PME_CTRL_CHAN];
  wire logic rel_on = ctrl[`PME_CTRL_REL];
  wire logic [1:0] mode = ctrl[`PME_CTRL_MODE_HI:`PME_CTRL_MODE_LO];

  // ----------------------------------------
  // Factor candidates
  // ----------------------------------------
  wire logic in_entry = (state == pme_pkg::st_entry);
  wire logic enter_wr = cmd_wr && in_entry && (op == pme_pkg::op_enter);
  wire logic dig_ok = dcnt < `PME_MAX_DIGITS;
  wire logic [31:0] keyed = 32'(acc) * `PME_TEN + 32'(frac);
  wire logic [31:0] rounded = (pwdata + `PME_HALF) / `PME_TEN;
  wire logic [31:0] cand = remote_wr ? rounded :
                           (dcnt == 3'h0) ? 32'(`PME_CF_UNITY) : keyed;
  wire logic cf_wr = enter_wr | remote_wr;
  wire logic cf_take = cf_wr && cf_ok(cand);
  wire logic cf_reject = cf_wr && !cf_ok(cand);

  // ----------------------------------------
  // Measurement path
  // ----------------------------------------
  // Reference factor only while calibrating
  wire logic [15:0] gain_a = ctrl[`PME_CTRL_CAL] ? refcal : cf_a;
  wire logic [15:0] gain_b = ctrl[`PME_CTRL_CAL] ? refcal : cf_b;
  wire logic signed [31:0] corr_a = scale(meas_a, gain_a);
  wire logic signed [31:0] corr_b = scale(meas_b, gain_b);
  wire logic signed [31:0] raw = (mode == 2'h0) ? corr_a :
                                 (mode == 2'h1) ? corr_b :
                                 (mode == 2'h2) ? corr_a - corr_b : corr_b - corr_a;
  wire logic signed [31:0] value = rel_on ? raw - ref_val : raw;
  // Negative difference in log units without relative mode
  wire logic diff_refused = !rel_on && mode[1] && (raw < 0);
  wire logic log_err = unit_is_log && ((value <= 0) || diff_refused);

  // ----------------------------------------
  // Error classification
  // ----------------------------------------
  wire logic [7:0] err_now = log_err ? `PME_ERR_LOG :
                             (entry_err != `PME_ERR_NONE) ? entry_err : ext_err;
  wire pme_pkg::pme_class_type cls = err_class(err_now);
  wire logic err_new = (err_now != `PME_ERR_NONE) && (err_now != err_prev);
  wire logic srq_sel = ((cls == pme_pkg::cls_meas) && ctrl[`PME_CTRL_SRQ_MEAS]) ||
                       ((cls == pme_pkg::cls_entry) && ctrl[`PME_CTRL_SRQ_ENT]) ||
                       (cls == pme_pkg::cls_service);
  wire logic sent_rd = rd_en && (paddr == `PME_RESULT_OFS) && error_shown;
  wire logic stat_rd = rd_en && (paddr == `PME_STATMSG_OFS);
  wire logic latch_new = err_new && (srq_sel || (cls == pme_pkg::cls_entry));
  wire logic latch_sent = meas_pend && sent_rd;
  wire logic latch_now = latch_new | latch_sent;

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  wire logic hit = (paddr[1:0] == 2'h0) && (paddr <= `PME_STATMSG_OFS);
  logic [31:0] rd_data;
  always_comb begin
    case (paddr)
      `PME_CTRL_OFS: rd_data = {25'h0, ctrl};
      `PME_REFCAL_OFS: rd_data = {16'h0, refcal};
      `PME_CF_A_OFS: rd_data = {16'h0, cf_a};
      `PME_CF_B_OFS: rd_data = {16'h0, cf_b};
      `PME_EXT_ERR_OFS: rd_data = {24'h0, ext_err};
      // Sentinel while an error is shown
      `PME_RESULT_OFS: rd_data = error_shown ? `PME_SENTINEL : value;
      `PME_STATUS_OFS: rd_data = {22'h0, in_entry, unit_is_log, err_now};
      `PME_STATMSG_OFS: rd_data = {23'h0, srq, stat_code};
      default: rd_data = 32'h0;
    endcase
  end

  // ----------------------------------------
  // APB answer, no wait state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_data : 32'h0;
      pslverr <= setup && !hit;
    end
  end

  // ----------------------------------------
  // Control and data registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PME_CTRL_RST;
      refcal <= `PME_CF_UNITY;
      ext_err <= `PME_ERR_NONE;
      meas_a <= 32'sh0;
      meas_b <= 32'sh0;
    end else begin
      if (ctrl_wr) ctrl <= pwdata[6:0];
      if (wr_en && paddr == `PME_REFCAL_OFS) refcal <= pwdata[15:0];
      if (wr_en && paddr == `PME_EXT_ERR_OFS) ext_err <= pwdata[7:0];
      if (ma_wr) meas_a <= pwdata;
      if (mb_wr) meas_b <= pwdata;
    end
  end

  // ----------------------------------------
  // Relative reference capture
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_upd <= 1'b0;
      rel_arm <= 1'b0;
      ref_val <= 32'sh0;
    end else begin
      meas_upd <= ma_wr | mb_wr;
      if (ctrl_wr && pwdata[`PME_CTRL_REL] && !rel_on) begin
        rel_arm <= 1'b1; // Arm on activation
        ref_val <= 32'sh0;
      end else if (rel_arm && meas_upd) begin
        rel_arm <= 1'b0;
        ref_val <= raw;
      end
    end
  end

  // ----------------------------------------
  // Keypad entry state machine
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pme_pkg::st_idle;
      acc <= 16'h0;
      frac <= 4'h0;
      dcnt <= 3'h0;
      point_seen <= 1'b0;
      frac_seen <= 1'b0;
    end else if (preset) begin
      state <= pme_pkg::st_idle;
    end else if (cmd_wr) begin
      case (state)
        pme_pkg::st_idle: begin
          if (op == pme_pkg::op_sensor_gain_factor_cmd) begin
            state <= pme_pkg::st_entry;
            acc <= 16'h0;
            frac <= 4'h0;
            dcnt <= 3'h0;
            point_seen <= 1'b0;
            frac_seen <= 1'b0;
          end
        end
        pme_pkg::st_entry: begin
          if (op == pme_pkg::op_enter) begin
            state <= pme_pkg::st_idle;
          end else if (op == pme_pkg::op_point) begin
            point_seen <= 1'b1;
          end else if (op == pme_pkg::op_digit && dig_ok && !point_seen) begin
            acc <= 16'(acc * 16'hA + 16'(digit));
            dcnt <= dcnt + 3'h1;
          end else if (op == pme_pkg::op_digit && dig_ok && !frac_seen) begin
            frac <= digit;
            frac_seen <= 1'b1;
            dcnt <= dcnt + 3'h1;
          end
        end
        default: state <= pme_pkg::st_idle;
      endcase
    end
  end

  // ----------------------------------------
  // Per channel factors
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_a <= `PME_CF_UNITY;
      cf_b <= `PME_CF_UNITY;
    end else if (preset) begin
      cf_a <= `PME_CF_UNITY;
      cf_b <= `PME_CF_UNITY;
    end else if (cf_take && !chan) begin
      cf_a <= cand[15:0];
    end else if (cf_take && chan) begin
      cf_b <= cand[15:0];
    end
  end

  // ----------------------------------------
  // Units and panel outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_is_log <= 1'b0;
      entry_prompt <= 1'b0;
      error_shown <= 1'b0;
    end else begin
      if (preset || (cmd_wr && op == pme_pkg::op_linear_units_cmd)) begin
        unit_is_log <= 1'b0;
      end else if (cmd_wr && op == pme_pkg::op_log_units_cmd) begin
        unit_is_log <= 1'b1;
      end else if (cmd_wr && op == pme_pkg::op_unit_toggle_key) begin
        unit_is_log <= ~unit_is_log;
      end
      entry_prompt <= (state == pme_pkg::st_entry);
      error_shown <= (err_now != `PME_ERR_NONE);
    end
  end

  // ----------------------------------------
  // Entry error and status latch
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_err <= `PME_ERR_NONE;
      err_prev <= `PME_ERR_NONE;
      stat_code <= `PME_ERR_NONE;
      srq <= 1'b0;
      meas_pend <= 1'b0;
    end else begin
      // Next command clears a shown entry error; a rejection wins
      if (cf_reject) entry_err <= `PME_ERR_CF_RANGE;
      else if (cmd_wr) entry_err <= `PME_ERR_NONE;
      err_prev <= err_now;
      if (latch_now) begin
        stat_code <= err_now;
        srq <= srq | (latch_new & srq_sel);
      end else if (stat_rd && err_now == `PME_ERR_NONE) begin
        stat_code <= `PME_ERR_NONE;
        srq <= 1'b0;
      end
      if (err_new && cls == pme_pkg::cls_meas && !srq_sel) meas_pend <= 1'b1;
      else if (latch_sent || err_now == `PME_ERR_NONE) meas_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_select;
    cmd_wr && (op == pme_pkg::op_sensor_gain_factor_cmd) && !in_entry;
  endsequence
  sequence s_empty_enter;
    enter_wr && (dcnt == 3'h0) && !chan;
  endsequence

  AST_CF_RANGE: assert property (cf_ok(32'(cf_a)) && cf_ok(32'(cf_b)))
    else $error("factor out of range");
  AST_DIGITS: assert property (dcnt <= `PME_MAX_DIGITS)
    else $error("more than four digits kept");
  AST_FRAC: assert property (cmd_wr && in_entry && frac_seen && op == pme_pkg::op_digit
    |=> $stable(frac) && $stable(acc))
    else $error("extra fractional digit taken");
  AST_PROMPT: assert property (s_select |=> ##1 entry_prompt)
    else $error("prompt not shown");
  AST_EMPTY: assert property (s_select ##[1:8] s_empty_enter
    |=> cf_a == `PME_CF_UNITY ##1 !entry_prompt)
    else $error("empty entry not unity");
  AST_PRESET: assert property (preset
    |=> cf_a == `PME_CF_UNITY && cf_b == `PME_CF_UNITY && !unit_is_log)
    else $error("preset state wrong");
  AST_TOGGLE: assert property (cmd_wr && op == pme_pkg::op_unit_toggle_key
    |=> unit_is_log != $past(unit_is_log))
    else $error("unit key did not toggle");
  AST_MODE_KEEP: assert property (ctrl_wr && !cmd_wr |=> $stable(unit_is_log))
    else $error("mode change altered units");
  AST_LOG_ERR: assert property (unit_is_log && value <= 0
    |-> err_now == `PME_ERR_LOG ##1 error_shown)
    else $error("log error missing");
  AST_SENTINEL: assert property (setup && !pwrite && paddr == `PME_RESULT_OFS &&
    error_shown |=> prdata == `PME_SENTINEL)
    else $error("sentinel not returned");
  AST_ENTRY_LATCH: assert property (err_new && cls == pme_pkg::cls_entry
    |=> stat_code == $past(err_now))
    else $error("entry error not latched");

endmodule : pme_entry_status

`default_nettype wire

// File: pme_apb_master.sv
// APB controller model standing in for the panel and the remote bus.
// Assumes one rising-edge clock; requests change just after an edge.
`timescale 1ns/1ns
`default_nettype none

module pme_apb_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // ----------------------------------------
  // One transfer, held until pready is seen
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the answer; only the bench timeout ends a hang
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry inverted junk, never the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : pme_apb_master
`default_nettype wire

// File: pme_entry_status_tb.sv
// Self-checking bench for the entry and error status block.
// Assumes the controller model drives the APB side.
`timescale 1ns/1ns
`include "pme_consts.svh"
`default_nettype none

module pme_entry_status_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0; // Bus clock
  logic presetn = 1'b0; // Reset, low active
  wire logic psel, penable, pwrite, pready, pslverr; // Bus strobes
  wire logic [7:0] paddr; // Byte address
  wire logic [31:0] pwdata, prdata; // Data lines
  wire logic entry_prompt, unit_is_log, error_shown, srq; // Status pins
  int error_cnt = 0; // Mismatches
  int comparisons = 0; // Compares made
  int cycles = 0; // Hang guard
  localparam logic [7:0] a_ctl = `PME_CTRL_OFS; // Short aliases
  localparam logic [7:0] a_sm = `PME_STATMSG_OFS;
  localparam logic [7:0] a_st = `PME_STATUS_OFS;
  localparam logic [7:0] a_res = `PME_RESULT_OFS;

  always #10 pclk = ~pclk;

  // Design under test
  pme_entry_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .entry_prompt(entry_prompt), .unit_is_log(unit_is_log),
    .error_shown(error_shown), .srq(srq));
  // Controller model
  pme_apb_master master_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    master_u.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    master_u.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp, what);
  endtask : rdc

  task automatic op(input pme_pkg::pme_op_type o, input logic [3:0] dg);
    wr(`PME_CMD_OFS, {24'h0, dg, o});
  endtask : op

  // Let registered status pins catch up
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle

  // Select, key a string of digits and point, then enter
  task automatic keys(input string s);
    op(pme_pkg::op_sensor_gain_factor_cmd, 4'h0);
    for (int i = 0; i < s.len(); i++) begin
      if (s[i] == ".")
        op(pme_pkg::op_point, 4'h0);
      else
        op(pme_pkg::op_digit, 4'(s[i] - "0"));
    end
    op(pme_pkg::op_enter, 4'h0);
  endtask : keys

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rdc(`PME_CF_A_OFS, 32'h3E8, "cf a");
    rdc(`PME_CF_B_OFS, 32'h3E8, "cf b");
    chk(unit_is_log, 32'h0, "units");
    master_u.xfer(1'b0, 8'h30, 32'h0, q, e);
    chk(e, 32'h1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    $display("done: reset");
  endtask : t_reset

  task automatic t_keypad();
    wr(a_ctl, 32'h0);
    keys("99.57");
    rdc(`PME_CF_A_OFS, 32'h3E3, "one fraction digit");
    keys("00123");
    rdc(`PME_CF_A_OFS, 32'h78, "four digits");
    op(pme_pkg::op_sensor_gain_factor_cmd, 4'h0);
    settle();
    chk(entry_prompt, 32'h1, "prompt on");
    op(pme_pkg::op_enter, 4'h0);
    settle();
    chk(entry_prompt, 32'h0, "prompt off");
    rdc(`PME_CF_A_OFS, 32'h3E8, "empty entry");
    wr(a_ctl, 32'h1);
    keys("1.0");
    rdc(`PME_CF_B_OFS, 32'hA, "low bound");
    rdc(`PME_CF_A_OFS, 32'h3E8, "other channel");
    keys("0.9");
    rdc(`PME_CF_B_OFS, 32'hA, "below range");
    rdc(a_st, 32'h32, "entry code");
    keys("150.1");
    rdc(`PME_CF_B_OFS, 32'hA, "above range");
    keys("150");
    rdc(`PME_CF_B_OFS, 32'h5DC, "high bound");
    rdc(a_sm, 32'h32, "entry latched");
    rdc(a_sm, 32'h0, "cleared by read");
    $display("done: keypad");
  endtask : t_keypad

  task automatic t_remote();
    wr(a_ctl, 32'h0);
    wr(`PME_REMOTE_CF_OFS, 32'd1235);
    rdc(`PME_CF_A_OFS, 32'h7C, "rounded");
    wr(`PME_REMOTE_CF_OFS, 32'd15004);
    rdc(`PME_CF_A_OFS, 32'h5DC, "round to max");
    wr(`PME_REMOTE_CF_OFS, 32'd15005);
    rdc(`PME_CF_A_OFS, 32'h5DC, "round past max");
    op(pme_pkg::op_none, 4'h0);
    rdc(a_sm, 32'h32, "remote entry err");
    $display("done: remote");
  endtask : t_remote

  task automatic t_units();
    op(pme_pkg::op_unit_toggle_key, 4'h0);
    settle();
    chk(unit_is_log, 32'h1, "toggle to log");
    wr(a_ctl, 32'h8);
    settle();
    chk(unit_is_log, 32'h1, "mode keeps units");
    op(pme_pkg::op_unit_toggle_key, 4'h0);
    settle();
    chk(unit_is_log, 32'h0, "toggle back");
    op(pme_pkg::op_log_units_cmd, 4'h0);
    settle();
    chk(unit_is_log, 32'h1, "log cmd");
    op(pme_pkg::op_linear_units_cmd, 4'h0);
    settle();
    chk(unit_is_log, 32'h0, "linear cmd");
    op(pme_pkg::op_log_units_cmd, 4'h0);
    op(pme_pkg::op_preset, 4'h0);
    settle();
    chk(unit_is_log, 32'h0, "preset units");
    rdc(`PME_CF_A_OFS, 32'h3E8, "preset a");
    rdc(`PME_CF_B_OFS, 32'h3E8, "preset b");
    $display("done: units");
  endtask : t_units

  task automatic t_result();
    wr(a_ctl, 32'h0);
    wr(`PME_MEAS_A_OFS, 32'd500);
    rdc(a_res, 32'd500, "plain result");
    wr(`PME_REFCAL_OFS, 32'd500);
    wr(a_ctl, 32'h10);
    rdc(a_res, 32'd250, "cal cycle gain");
    wr(a_ctl, 32'h2);
    wr(`PME_MEAS_A_OFS, 32'd300);
    wr(`PME_MEAS_A_OFS, 32'd500);
    rdc(a_res, 32'd200, "relative");
    $display("done: result");
  endtask : t_result

  task automatic t_errors();
    wr(a_ctl, 32'h20);
    wr(`PME_MEAS_A_OFS, 32'd0);
    op(pme_pkg::op_log_units_cmd, 4'h0);
    settle();
    chk(error_shown, 32'h1, "log error");
    rdc(a_st, 32'h11B, "code 27");
    rdc(a_res, `PME_SENTINEL, "sentinel");
    wr(`PME_MEAS_A_OFS, 32'd100);
    settle();
    chk(srq, 32'h1, "srq held");
    rdc(a_sm, 32'h11B, "latched 27");
    settle();
    chk(srq, 32'h0, "srq cleared");
    wr(a_ctl, 32'h28);
    wr(`PME_MEAS_B_OFS, 32'd200);
    rdc(a_st, 32'h11B, "neg difference");
    wr(`PME_MEAS_B_OFS, 32'd50);
    rdc(a_st, 32'h100, "pos difference");
    rdc(a_sm, 32'h11B, "diff latched");
    wr(a_ctl, 32'h2C);
    rdc(a_st, 32'h11B, "neg b minus a");
    wr(`PME_MEAS_B_OFS, 32'd200);
    rdc(a_sm, 32'h11B, "b minus a latched");
    op(pme_pkg::op_linear_units_cmd, 4'h0);
    wr(a_ctl, 32'h40);
    wr(`PME_EXT_ERR_OFS, 32'h31);
    settle();
    chk(srq, 32'h0, "meas class");
    wr(`PME_EXT_ERR_OFS, 32'h5A);
    settle();
    chk(srq, 32'h1, "entry class");
    wr(`PME_EXT_ERR_OFS, 32'h3C);
    rdc(a_sm, 32'h13C, "newest kept");
    wr(`PME_EXT_ERR_OFS, 32'h0);
    rdc(a_sm, 32'h13C, "read clears");
    wr(a_ctl, 32'h0);
    op(pme_pkg::op_log_units_cmd, 4'h0);
    wr(`PME_MEAS_A_OFS, 32'd0);
    rdc(a_sm, 32'h0, "not yet latched");
    rdc(a_res, `PME_SENTINEL, "sentinel sent");
    rdc(a_sm, 32'h1B, "latched after send");
    $display("done: errors");
  endtask : t_errors

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_keypad();
    t_remote();
    t_units();
    t_result();
    t_errors();
    conclude();
  end
endmodule : pme_entry_status_tb
`default_nettype wire
